// ### discard_cfg_pkg.sv
/*
  Constants shared by the yellow-packet discard table and the port 2 egress tag rules.
  Assumes one 100 MHz switch clock and an active-low asynchronous fabric reset.
*/
// Summary of operation
// - Table entries are never initialised by reset
// - Write value holds 10-bit probability, 1/1024
// - Only yellow packets are subject to discard
// - Sixteen entries, indexed by buffer usage range
// - Read value shows entry from last read
// - Command write acts now; bit4 read, 3:0 index
// - Usage ranges: steps 8, 16, 32 up to 255
// - Type field: dumb, access, hybrid, CPU
// - Value source picks ingress or egress defaults
// - Tag modifier bits act only in hybrid
// - Insert tags untagged packets when untag clear
// - Regular-tag VID change needs retag and clear untag
// - Hybrid priority-tagged packets always get default VID
// - Priority change; regular tags need retag too
// - Retag gates regular tagged packets only
package discard_cfg_pkg;

  // ---------------------------------------------------------------
  // Register indices (word address is four times the index)
  // ---------------------------------------------------------------
  localparam logic [15:0] CMD_IDX = 16'h1c09;
  localparam logic [15:0] WVAL_IDX = 16'h1c0a;
  localparam logic [15:0] RVAL_IDX = 16'h1c0b;
  localparam logic [15:0] TAG_IDX = 16'h1c0c;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int PROB_W = 10;
  localparam int DIR_BIT = 4;
  localparam int TYPE_LO = 16;
  localparam int RETAG_BIT = 18;
  localparam int CHPRI_BIT = 19;
  localparam int CHVID_BIT = 20;
  localparam int INSERT_BIT = 21;
  localparam int SRC_BIT = 22;
  localparam int TAG_MSB = 22;

  // Reset values
  localparam logic [9:0] PROB_RST = 10'h000;
  localparam logic [4:0] CMD_RST = 5'h00;
  localparam logic [6:0] TAG_RST = 7'h00;
  localparam logic [15:0] LFSR_SEED = 16'hace1;

  // Egress port types
  typedef enum logic [1:0] {
    TYPE_DUMB = 2'h0,
    TYPE_ACCESS = 2'h1,
    TYPE_HYBRID = 2'h2,
    TYPE_CPU = 2'h3
  } egress_type_t;

endpackage : discard_cfg_pkg

// ### discard_table_and_egress_tag_cfg.sv
/*
  Register bank for the yellow-packet random discard table and port 2 egress tag rules,
  with the per-packet discard decision and the tag action decode.
  Assumes a plain same-clock register port and per-packet strobes from the buffer manager.
*/
`timescale 1ns/100ps
module discard_table_and_egress_tag_cfg
#(
  parameter int ENTRIES = 16
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Register port
  input wire logic [15:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdata,
  // Discard request
  input wire logic pktValid,
  input wire logic pktYellow,
  input wire logic [7:0] pktUsage,
  output logic dropValid,
  output logic dropPkt,
  // Tag request
  input wire logic tagValid,
  input wire logic pktTagged,
  input wire logic pktPrioTagged,
  input wire logic untagDefault,
  input wire logic untagIncoming,
  input wire logic [11:0] ingressVid,
  input wire logic [2:0] ingressPri,
  input wire logic [11:0] egressVid,
  input wire logic [2:0] egressPri,
  output logic actValid,
  output logic actInsert,
  output logic actStrip,
  output logic actSetVid,
  output logic actSetPri,
  output logic [11:0] actVid,
  output logic [2:0] actPri,
  output logic [1:0] egressType
);
  import discard_cfg_pkg::*;

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [9:0] wval;
    logic [9:0] rval;
    logic [4:0] cmd;
    logic [6:0] tag;
    logic [15:0] lfsr;
    logic [31:0] rdata;
    logic dropValid;
    logic dropPkt;
    logic actValid;
    logic actInsert;
    logic actStrip;
    logic actSetVid;
    logic actSetPri;
    logic [11:0] actVid;
    logic [2:0] actPri;
  } state_t;

  state_t s_q;
  state_t s_d;

  // Table has no reset: contents stay undefined until written
  // no table init
  logic [9:0] table_q [ENTRIES];
  logic tblWr;
  logic [3:0] tblIdx;
  logic [3:0] usageIdx;

  usage_to_index u_map
  (
    .usage(pktUsage),
    .index(usageIdx)
  );

  // Tag field view of the packed config
  function automatic logic fieldBit(input logic [6:0] t, input int pos);
    fieldBit = t[pos - TYPE_LO];
  endfunction : fieldBit

  function automatic logic [15:0] lfsrStep(input logic [15:0] v);
    lfsrStep = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : lfsrStep

  logic hybrid;
  logic cmdWr;
  assign cmdWr = regWr && (regAddr == CMD_IDX);
  assign tblIdx = regWdata[3:0];
  assign tblWr = cmdWr && !regWdata[DIR_BIT];
  assign hybrid = (s_q.tag[1:0] == TYPE_HYBRID);

  // ---------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------
  always_comb
  begin
    logic retag;
    logic chVid;
    logic chPri;
    logic ins;
    logic src;
    retag = 1'b0;
    chVid = 1'b0;
    chPri = 1'b0;
    ins = 1'b0;
    src = 1'b0;
    s_d = s_q;
    s_d.lfsr = lfsrStep(s_q.lfsr);

    // Register writes
    if (regWr)
    begin
      case (regAddr)
        CMD_IDX:
        begin
          s_d.cmd = regWdata[4:0];
          if (regWdata[DIR_BIT])
            s_d.rval = table_q[regWdata[3:0]];
        end
        WVAL_IDX: s_d.wval = regWdata[PROB_W-1:0];
        TAG_IDX: s_d.tag = regWdata[TAG_MSB:TYPE_LO];
        default: s_d.wval = s_q.wval;
      endcase
    end

    // Read data in the following cycle; reserved bits read zero
    // reserved zero
    s_d.rdata = 32'h0000_0000;
    if (regRd)
    begin
      case (regAddr)
        CMD_IDX: s_d.rdata = {27'h000_0000, s_q.cmd};
        WVAL_IDX: s_d.rdata = {22'h00_0000, s_q.wval};
        RVAL_IDX: s_d.rdata = {22'h00_0000, s_q.rval};
        TAG_IDX: s_d.rdata = {9'h000, s_q.tag, 16'h0000};
        default: s_d.rdata = 32'h0000_0000;
      endcase
    end

    // Discard decision, a fresh random draw each packet
    // yellow only
    s_d.dropValid = pktValid;
    s_d.dropPkt = pktValid && pktYellow && (s_q.lfsr[9:0] < table_q[usageIdx]);

    // Tag action decode
    if (hybrid)
    begin
      retag = fieldBit(s_q.tag, RETAG_BIT);
      chVid = fieldBit(s_q.tag, CHVID_BIT);
      chPri = fieldBit(s_q.tag, CHPRI_BIT);
      ins = fieldBit(s_q.tag, INSERT_BIT);
      src = fieldBit(s_q.tag, SRC_BIT);
    end
    s_d.actValid = tagValid;
    s_d.actInsert = 1'b0;
    s_d.actStrip = 1'b0;
    s_d.actSetVid = 1'b0;
    s_d.actSetPri = 1'b0;
    s_d.actVid = src ? egressVid : ingressVid;
    s_d.actPri = src ? egressPri : ingressPri;
    case (egress_type_t'(s_q.tag[1:0]))
      TYPE_ACCESS: s_d.actStrip = tagValid && pktTagged;
      TYPE_HYBRID:
      begin
        if (!pktTagged && !pktPrioTagged)
          s_d.actInsert = tagValid && ins && !untagDefault;
        else if (pktPrioTagged)
        begin
          s_d.actSetVid = tagValid;
          s_d.actSetPri = tagValid && chPri;
        end
        else if ((chVid || chPri) && retag)
        begin
          s_d.actStrip = tagValid && untagIncoming;
          s_d.actSetVid = tagValid && !untagIncoming && chVid;
          s_d.actSetPri = tagValid && !untagIncoming && chPri;
        end
      end
      default: s_d.actStrip = 1'b0;
    endcase
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      s_q <= '0;
      s_q.lfsr <= LFSR_SEED;
      s_q.wval <= PROB_RST;
      s_q.rval <= PROB_RST;
      s_q.cmd <= CMD_RST;
      s_q.tag <= TAG_RST;
    end
    else
      s_q <= s_d;
  end

  // Table write from the staged value
  // sixteen entries
  always_ff @(posedge clk)
  begin
    if (tblWr)
      table_q[tblIdx] <= s_q.wval;
  end

  assign regRdata = s_q.rdata;
  assign dropValid = s_q.dropValid;
  assign dropPkt = s_q.dropPkt;
  assign actValid = s_q.actValid;
  assign actInsert = s_q.actInsert;
  assign actStrip = s_q.actStrip;
  assign actSetVid = s_q.actSetVid;
  assign actSetPri = s_q.actSetPri;
  assign actVid = s_q.actVid;
  assign actPri = s_q.actPri;
  assign egressType = s_q.tag[1:0];

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  sequence tblWriteSeq;
    regWr && regAddr == CMD_IDX && !regWdata[DIR_BIT];
  endsequence

  a_table_write: assert property (@(posedge clk) disable iff (!rstn)
    tblWriteSeq |=> table_q[$past(regWdata[3:0])] == $past(s_q.wval))
    else $error("table write lost");

  // Read command fetches the entry, a later read of the read value shows it
  sequence rdCmdSeq;
    regWr && regAddr == CMD_IDX && regWdata[DIR_BIT];
  endsequence

  sequence rvalRdSeq;
    regRd && regAddr == RVAL_IDX;
  endsequence

  a_read_fetch: assert property (@(posedge clk) disable iff (!rstn)
    rdCmdSeq |=> s_q.rval == table_q[$past(regWdata[3:0])])
    else $error("read fetch wrong");

  a_read_value: assert property (@(posedge clk) disable iff (!rstn)
    rvalRdSeq |=> regRdata == {22'h00_0000, $past(s_q.rval)})
    else $error("read value wrong");

  a_cmd_held: assert property (@(posedge clk) disable iff (!rstn)
    (regWr && regAddr == CMD_IDX) |=> s_q.cmd == $past(regWdata[4:0]))
    else $error("command not held");

  // Idle read port must not leak stale data onto the bus
  a_rdata_idle: assert property (@(posedge clk) disable iff (!rstn)
    !regRd |=> regRdata == 32'h0000_0000)
    else $error("read data while idle");

  a_wval_width: assert property (@(posedge clk) disable iff (!rstn)
    (regRd && regAddr == WVAL_IDX) |=> regRdata[31:10] == 22'h00_0000)
    else $error("write value upper bits set");

  a_green_kept: assert property (@(posedge clk) disable iff (!rstn)
    (pktValid && !pktYellow) |=> dropValid && !dropPkt)
    else $error("non-yellow dropped");

  a_hybrid_only: assert property (@(posedge clk) disable iff (!rstn)
    (s_q.tag[1:0] != TYPE_HYBRID) |=> !actInsert && !actSetVid && !actSetPri)
    else $error("modifier outside hybrid");

  a_insert_gate: assert property (@(posedge clk) disable iff (!rstn)
    (tagValid && untagDefault) |=> !actInsert)
    else $error("insert despite untag");

  a_prio_vid: assert property (@(posedge clk) disable iff (!rstn)
    (tagValid && pktPrioTagged && hybrid) |=> actSetVid)
    else $error("priority tag VID kept");

  a_strip_untag: assert property (@(posedge clk) disable iff (!rstn)
    (tagValid && hybrid && pktTagged && !pktPrioTagged && untagIncoming && s_q.tag[2]
     && (s_q.tag[4] || s_q.tag[3])) |=> actStrip && !actSetVid && !actSetPri)
    else $error("tag not removed");

  a_src_select: assert property (@(posedge clk) disable iff (!rstn)
    (hybrid && s_q.tag[6] && tagValid) |=> actVid == $past(egressVid))
    else $error("wrong VID source");

  a_tag_reset: assert property (@(posedge clk)
    !rstn |-> s_q.tag == TAG_RST)
    else $error("tag config not reset");

  // Discard checks
  a_drop_idle: assert property (@(posedge clk) disable iff (!rstn)
    !pktValid |=> !dropValid && !dropPkt)
    else $error("drop without packet");

  a_drop_zero: assert property (@(posedge clk) disable iff (!rstn)
    (pktValid && table_q[usageIdx] == 10'h000) |=> !dropPkt)
    else $error("drop at zero probability");

  // Tag action checks
  a_access_strip: assert property (@(posedge clk) disable iff (!rstn)
    (tagValid && s_q.tag[1:0] == TYPE_ACCESS) |=> actStrip == $past(pktTagged))
    else $error("access strip wrong");

  a_dumb_idle: assert property (@(posedge clk) disable iff (!rstn)
    (tagValid && (s_q.tag[1:0] == TYPE_DUMB || s_q.tag[1:0] == TYPE_CPU))
    |=> !actInsert && !actStrip && !actSetVid && !actSetPri)
    else $error("action on dumb or cpu port");

  a_insert_tag: assert property (@(posedge clk) disable iff (!rstn)
    (tagValid && hybrid && s_q.tag[5] && !pktTagged && !pktPrioTagged && !untagDefault) |=> actInsert)
    else $error("tag not inserted");

  a_retag_gate: assert property (@(posedge clk) disable iff (!rstn)
    (tagValid && hybrid && pktTagged && !pktPrioTagged && !s_q.tag[2])
    |=> !actStrip && !actSetVid && !actSetPri)
    else $error("change without retag");

  a_prio_pri: assert property (@(posedge clk) disable iff (!rstn)
    (tagValid && hybrid && pktPrioTagged && s_q.tag[3]) |=> actSetPri)
    else $error("priority not changed");

  a_src_pri: assert property (@(posedge clk) disable iff (!rstn)
    (tagValid && hybrid && !s_q.tag[6]) |=> actPri == $past(ingressPri))
    else $error("wrong priority source");

endmodule : discard_table_and_egress_tag_cfg

// ### discard_table_and_egress_tag_cfg_bench.sv
/*
  Self-checking bench for the discard table and port 2 egress tag rule bank.
  Assumes the register port answers reads one cycle later and requests act one cycle later.
*/
`timescale 1ns/100ps
module discard_table_and_egress_tag_cfg_bench;
  import discard_cfg_pkg::*;
  // ------------------------------------------------
  // Stimulus and observed signals
  // ------------------------------------------------
  logic clk = 0, rstn, regWr = 0, regRd = 0, pktValid = 0, pktYellow = 0, tagValid = 0;
  logic pktTagged = 0, pktPrioTagged = 0, untagDefault = 0, untagIncoming = 0;
  logic [15:0] regAddr = 16'h0000;
  logic [31:0] regWdata = 32'h0000_0000, regRdata;
  logic [7:0] pktUsage = 8'h00;
  logic [11:0] ingressVid = 12'h123, egressVid = 12'h456, actVid;
  logic [2:0] ingressPri = 3'h3, egressPri = 3'h5, actPri;
  logic dropValid, dropPkt, actValid, actInsert, actStrip, actSetVid, actSetPri;
  logic [1:0] egressType;
  int fail_count = 0, compares = 0, cycles = 0, drops;
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin fail_count++; \
  $display("ERROR t=%0t got %0h exp %0h", $time, g, e); end end
  discard_table_and_egress_tag_cfg #(.ENTRIES(16)) uut (.clk(clk), .rstn(rstn), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .pktValid(pktValid),
    .pktYellow(pktYellow), .pktUsage(pktUsage), .dropValid(dropValid), .dropPkt(dropPkt),
    .tagValid(tagValid), .pktTagged(pktTagged), .pktPrioTagged(pktPrioTagged),
    .untagDefault(untagDefault), .untagIncoming(untagIncoming), .ingressVid(ingressVid),
    .ingressPri(ingressPri), .egressVid(egressVid), .egressPri(egressPri), .actValid(actValid),
    .actInsert(actInsert), .actStrip(actStrip), .actSetVid(actSetVid), .actSetPri(actSetPri),
    .actVid(actVid), .actPri(actPri), .egressType(egressType));
  // Clock, and a ceiling well above the few hundred cycles the tests need
  initial forever #5 clk = ~clk;
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      fail_count++;
      summarize();
    end
  end
  // ------------------------------------------------
  // Bus and request tasks
  // ------------------------------------------------
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge clk);
    regWr <= 1'b0;
  endtask : wr
  // Read data is looked at only in the cycle after the strobe
  task automatic rd(input logic [15:0] a, output logic [31:0] d);
    @(posedge clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 1'b0;
    #1 d = regRdata;
  endtask : rd
  // Table access loads the write value before the command
  // value before command
  task automatic tblWr(input logic [3:0] i, input logic [9:0] v);
    wr(WVAL_IDX, {22'h0, v});
    wr(CMD_IDX, {28'h0, i});
  endtask : tblWr
  task automatic pkt(input logic y, input logic [7:0] u);
    @(posedge clk);
    pktValid <= 1'b1;
    pktYellow <= y;
    pktUsage <= u;
    @(posedge clk);
    pktValid <= 1'b0;
    #1 `CHK(dropValid, 1'b1)
  endtask : pkt
  // One tag request; flags are {insert, strip, setVid, setPri}
  task automatic tagCase(input logic [31:0] cfg, input logic [3:0] kind, input logic [3:0] fl,
                         input logic [11:0] v, input logic [2:0] p);
    wr(TAG_IDX, cfg);
    @(posedge clk);
    tagValid <= 1'b1;
    {pktTagged, pktPrioTagged, untagDefault, untagIncoming} <= kind;
    @(posedge clk);
    tagValid <= 1'b0;
    #1 `CHK(actValid, 1'b1)
    `CHK({actInsert, actStrip, actSetVid, actSetPri}, fl)
    if (fl[3] | fl[1]) `CHK(actVid, v)
    if (fl[0]) `CHK(actPri, p)
  endtask : tagCase
  function automatic logic [31:0] cfg(input logic [1:0] t, input logic [4:0] b);
    return {9'h0, b, t, 16'h0};
  endfunction : cfg
  // ------------------------------------------------
  // Scenarios
  // ------------------------------------------------
  task automatic testReset();
    logic [31:0] d;
    rd(TAG_IDX, d);
    `CHK(d, 32'h0000_0000)
    `CHK(egressType, 2'h0)
    rd(16'h1c20, d);
    `CHK(d, 32'h0000_0000)
    wr(TAG_IDX, 32'hffff_ffff);
    rd(TAG_IDX, d);
    `CHK(d, 32'h007f_0000)
    `CHK(egressType, 2'h3)
    $display("test reset done");
  endtask : testReset
  task automatic testTable();
    logic [31:0] d;
    for (int i = 0; i < 16; i++)
      tblWr(i[3:0], 10'(i * 64 + 5));
    tblWr(4'hf, 10'h3ff);
    for (int i = 0; i < 16; i++)
    begin
      wr(CMD_IDX, 32'h0000_0010 | i);
      rd(RVAL_IDX, d);
      `CHK(d, (i == 15) ? 32'h0000_03ff : 32'(i * 64 + 5))
    end
    wr(WVAL_IDX, 32'hffff_ffff);
    rd(WVAL_IDX, d);
    `CHK(d, 32'h0000_03ff)
    $display("test table done");
  endtask : testTable
  task automatic testDiscard();
    tblWr(4'h0, 10'h000);
    tblWr(4'h7, 10'h000);
    // Green packet at full probability never drops
    pkt(1'b0, 8'd255);
    `CHK(dropPkt, 1'b0)
    pkt(1'b1, 8'd7);
    `CHK(dropPkt, 1'b0)
    pkt(1'b1, 8'd63);
    `CHK(dropPkt, 1'b0)
    drops = 0;
    // Boundary 224 selects the 1023 entry, almost always dropped
    for (int i = 0; i < 8; i++)
    begin
      pkt(1'b1, 8'd224);
      drops += int'(dropPkt === 1'b1);
    end
    `CHK(drops >= 7, 1'b1)
    $display("test discard done");
  endtask : testDiscard
  task automatic testTag();
    // Bits {src, insert, chVid, chPri, retag}; kind {tagged, prio, untagDef, untagInc}
    tagCase(cfg(TYPE_DUMB, 5'h1f), 4'h8, 4'h0, 0, 0);
    tagCase(cfg(TYPE_CPU, 5'h1f), 4'h8, 4'h0, 0, 0);
    tagCase(cfg(TYPE_ACCESS, 5'h08), 4'h8, 4'h4, 0, 0);
    tagCase(cfg(TYPE_ACCESS, 5'h08), 4'h0, 4'h0, 0, 0);
    tagCase(cfg(TYPE_HYBRID, 5'h08), 4'h0, 4'h8, 12'h123, 0);
    tagCase(cfg(TYPE_HYBRID, 5'h08), 4'h2, 4'h0, 0, 0);
    tagCase(cfg(TYPE_HYBRID, 5'h15), 4'h8, 4'h2, 12'h456, 0);
    tagCase(cfg(TYPE_HYBRID, 5'h15), 4'h9, 4'h4, 0, 0);
    tagCase(cfg(TYPE_HYBRID, 5'h04), 4'h8, 4'h0, 0, 0);
    tagCase(cfg(TYPE_HYBRID, 5'h00), 4'h4, 4'h2, 12'h123, 0);
    tagCase(cfg(TYPE_HYBRID, 5'h12), 4'h4, 4'h3, 12'h456, 3'h5);
    tagCase(cfg(TYPE_HYBRID, 5'h03), 4'h8, 4'h1, 0, 3'h3);
    tagCase(cfg(TYPE_HYBRID, 5'h02), 4'h8, 4'h0, 0, 0);
    `CHK(egressType, TYPE_HYBRID)
    $display("test tag done");
  endtask : testTag
  // ------------------------------------------------
  // Verdict
  // ------------------------------------------------
  task automatic summarize();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : summarize
  // Reset for five cycles, then run every scenario
  initial
  begin
    rstn <= 1'b0;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    testReset();
    testTable();
    testDiscard();
    testTag();
    summarize();
  end
endmodule : discard_table_and_egress_tag_cfg_bench

// ### usage_to_index.sv
/*
  Maps an ingress port's used-buffer count onto one of sixteen table indices.
  Assumes the count is synchronous to the switch clock.
*/
`timescale 1ns/100ps
module usage_to_index
(
  // Buffer usage in, entry index out
  input wire logic [7:0] usage,
  output logic [3:0] index
);
  // Fine steps at low usage, coarser steps as the buffer fills
  // usage range map
  always_comb
  begin
    if (usage < 8'd64)
      index = {1'b0, usage[5:3]};
    else if (usage < 8'd128)
      index = {2'b10, usage[5:4]};
    else
      index = {2'b11, usage[6:5]};
  end
endmodule : usage_to_index
